// ===== dhi_pkg.sv
// constants shared by both ends of the display host port
// Functional notes
// - cpu type low separate, high enable strobes
// - interface type low serial, high parallel
// - reset low initialises; host holds it high
// - chip select high ignores all activity
// - command/data low command, high data
// - read strobe: enable high or read low
// - write strobe: direction or write low
// - serial mode: host holds strobes static
// - serial clock 17, in 16, out 15
// - parallel bus 17:9 or 17:10
// - serial mode: host ties unused pins low
// - drive bus on reads, sample on writes
// - processor mode: host ties video inputs high
// - host leaves vsync trigger undriven
// - external mode clocks from trim input
// - display off after reset until command
`default_nettype none
package dhi_pkg;
  // pin index inside the 9-bit bus, bit 8 is pin 17
  localparam int unsigned BUS_W   = 9;
  localparam int unsigned SCL_BIT = 8;
  localparam int unsigned SDI_BIT = 7;
  localparam int unsigned SDO_BIT = 6;
  localparam int unsigned SER_BITS = 8;
  localparam logic [2:0] SER_LAST = 3'h7;
  // display control opcodes
  localparam logic [7:0] CMD_DISP_ON  = 8'h06;
  localparam logic [7:0] CMD_DISP_OFF = 8'h07;
  // internal oscillator tick divider
  localparam logic [3:0] OSC_DIV_LAST = 4'h7;
  // host phase timing
  localparam int unsigned CLK_PS   = 5000;
  localparam int unsigned PHASE_NS = 100;
  localparam int unsigned PHASE_CYC =
    (PHASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SCL_HALF_NS = 50;
  localparam int unsigned SCL_HALF_CYC =
    (SCL_HALF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [4:0] PHASE_LAST =
    5'(PHASE_CYC - 1);
  localparam logic [4:0] SCL_LAST =
    5'(SCL_HALF_CYC - 1);
  typedef enum logic [2:0] {
    HS_IDLE   = 3'b000,
    HS_SETUP  = 3'b001,
    HS_ACTIVE = 3'b010,
    HS_REL    = 3'b011,
    HS_SLO    = 3'b100,
    HS_SHI    = 3'b101
  } dhi_hstate_t;
endpackage : dhi_pkg
`default_nettype wire

// ===== dhi_if.sv
// pins between host microcontroller and display controller
`timescale 1ns/1ps
`default_nettype none
interface dhi_if;
  logic       chip_reset_low;
  logic       chip_select_low;
  logic       command_data_select;
  logic       read_strobe;
  logic       write_strobe;
  logic       interface_type_select;
  logic       cpu_type_select;
  logic       osc_trim_in;
  logic       frame_sync_in;
  logic       line_sync_in;
  logic       pixel_clock_in;
  logic       video_enable_in;
  logic       vsync_trigger_out;
  logic [8:0] host_bus_h;
  logic [8:0] host_bus_h_oe_n;
  logic [8:0] host_bus_d;
  logic [8:0] host_bus_d_oe_n;
  logic [8:0] host_data_bus;
  // undriven pins settle low
  assign host_data_bus = (~host_bus_d_oe_n & host_bus_d)
    | (host_bus_d_oe_n & ~host_bus_h_oe_n & host_bus_h);
  modport dev (
    input  chip_reset_low, chip_select_low, command_data_select,
    input  read_strobe, write_strobe, interface_type_select,
    input  cpu_type_select, osc_trim_in, frame_sync_in,
    input  line_sync_in, pixel_clock_in, video_enable_in,
    input  host_data_bus,
    output host_bus_d, host_bus_d_oe_n, vsync_trigger_out
  );
  modport host (
    output chip_reset_low, chip_select_low, command_data_select,
    output read_strobe, write_strobe, interface_type_select,
    output cpu_type_select, osc_trim_in, frame_sync_in,
    output line_sync_in, pixel_clock_in, video_enable_in,
    output host_bus_h, host_bus_h_oe_n,
    input  host_data_bus, vsync_trigger_out
  );
endinterface : dhi_if
`default_nettype wire

// ===== dhi_dev.sv
// display controller end of the host port
`timescale 1ns/1ps
`default_nettype none
module dhi_dev (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // pins
  dhi_if.dev              pins,
  // static configuration
  input  wire logic       wide9_i,
  input  wire logic       ext_clk_mode_i,
  // read data source
  input  wire logic [8:0] rd_data_i,
  // received words
  output logic            wr_valid_o,
  output logic            wr_cmd_o,
  output logic [8:0]      wr_data_o,
  // state
  output logic            display_on_o,
  output logic            sys_tick_o
);
  logic       init;
  logic       serial_mode;
  logic       sep_mode;
  logic       sel;
  logic       act;
  logic       is_rd;
  logic [8:0] bus_word;
  logic       act_q;
  logic       act_wr_q;
  logic       act_rs_q;
  logic [8:0] cap_q;
  logic       scl_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] sin_q;
  logic [7:0] sout_q;
  logic [8:0] dout_q;
  logic [8:0] doe_n_q;
  logic       osc_q;
  logic [3:0] div_q;
  logic       commit;
  logic       commit_rs;
  logic [8:0] commit_data;
  logic       ser_rise;
  logic       ser_done;

  // chip reset pin acts alongside the system reset
  assign init        = rst_i | ~pins.chip_reset_low;
  assign serial_mode = ~pins.interface_type_select;
  assign sep_mode    = ~pins.cpu_type_select;
  assign sel         = ~pins.chip_select_low;

  // strobe decode per bus style
  always_comb
  begin
    if (sep_mode)
    begin
      act   = ~pins.read_strobe | ~pins.write_strobe;
      is_rd = ~pins.read_strobe;
    end
    else
    begin
      act   = pins.read_strobe;
      is_rd = ~pins.write_strobe;
    end
  end

  // width select: 8-bit bus uses pins 17:10 only
  always_comb
  begin
    if (wide9_i)
      bus_word = pins.host_data_bus;
    else
      bus_word = {1'b0, pins.host_data_bus[8:1]};
  end

  // parallel strobe tracking, data follows the bus while active
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      act_q    <= 1'b0;
      act_wr_q <= 1'b0;
      act_rs_q <= 1'b0;
      cap_q    <= 9'h000;
    end
    else
    begin
      act_q <= act & sel & ~serial_mode;
      if (act & sel & ~serial_mode)
      begin
        act_wr_q <= ~is_rd;
        act_rs_q <= pins.command_data_select;
        cap_q    <= bus_word;
      end
    end
  end

  // serial shift in on clock rise, out on the bit after
  assign ser_rise = serial_mode & sel & pins.host_data_bus[dhi_pkg::SCL_BIT]
                    & ~scl_q;
  assign ser_done = ser_rise & (bit_cnt_q == dhi_pkg::SER_LAST);

  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      scl_q     <= 1'b0;
      bit_cnt_q <= 3'h0;
      sin_q     <= 8'h00;
      sout_q    <= 8'h00;
    end
    else
    begin
      scl_q <= pins.host_data_bus[dhi_pkg::SCL_BIT];
      // a released select aborts any partial word
      if (!sel || !serial_mode)
      begin
        bit_cnt_q <= 3'h0;
        sout_q    <= rd_data_i[7:0];
      end
      else if (ser_rise)
      begin
        sin_q     <= {sin_q[6:0], pins.host_data_bus[dhi_pkg::SDI_BIT]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        sout_q    <= ser_done ? rd_data_i[7:0] : {sout_q[6:0], 1'b0};
      end
    end
  end

  // one word per strobe: parallel writes commit as the strobe releases, serial words on the eighth clock rise
  assign commit = (act_q & act_wr_q & ~(act & sel)) | ser_done;
  assign commit_rs = ser_done ? pins.command_data_select : act_rs_q;
  assign commit_data = ser_done ?
    {1'b0, sin_q[6:0], pins.host_data_bus[dhi_pkg::SDI_BIT]} : cap_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      wr_valid_o <= 1'b0;
      wr_cmd_o   <= 1'b0;
      wr_data_o  <= 9'h000;
    end
    else
    begin
      wr_valid_o <= commit;
      if (commit)
      begin
        wr_cmd_o  <= ~commit_rs;
        wr_data_o <= commit_data;
      end
    end
  end

  // display stays dark until an explicit on command
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      display_on_o <= 1'b0;
    else if (commit && !commit_rs)
    begin
      if (commit_data[7:0] == dhi_pkg::CMD_DISP_ON)
        display_on_o <= 1'b1;
      else if (commit_data[7:0] == dhi_pkg::CMD_DISP_OFF)
        display_on_o <= 1'b0;
    end
  end

  // pin drive; registered so read data appears one cycle after strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      dout_q  <= 9'h000;
      doe_n_q <= 9'h1ff;
    end
    else if (serial_mode)
    begin
      dout_q  <= 9'h000;
      doe_n_q <= 9'h1ff;
      if (sel)
      begin
        dout_q[dhi_pkg::SDO_BIT]  <= sout_q[7];
        doe_n_q[dhi_pkg::SDO_BIT] <= 1'b0;
      end
    end
    else if (act && sel && is_rd)
    begin
      dout_q  <= wide9_i ? rd_data_i : {rd_data_i[7:0], 1'b0};
      doe_n_q <= wide9_i ? 9'h000 : 9'h001;
    end
    else
    begin
      dout_q  <= 9'h000;
      doe_n_q <= 9'h1ff;
    end
  end

  assign pins.host_bus_d      = dout_q;
  assign pins.host_bus_d_oe_n = doe_n_q;
  // the trigger pin idles low; in processor mode nothing uses it
  assign pins.vsync_trigger_out = 1'b0;

  // system tick source select
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      osc_q      <= 1'b0;
      div_q      <= 4'h0;
      sys_tick_o <= 1'b0;
    end
    else
    begin
      osc_q <= pins.osc_trim_in;
      if (ext_clk_mode_i)
      begin
        div_q      <= 4'h0;
        sys_tick_o <= pins.osc_trim_in & ~osc_q;
      end
      else
      begin
        div_q      <= (div_q == dhi_pkg::OSC_DIV_LAST) ? 4'h0 : div_q + 4'h1;
        sys_tick_o <= (div_q == dhi_pkg::OSC_DIV_LAST);
      end
    end
  end

endmodule : dhi_dev
`default_nettype wire

// ===== dhi_host.sv
// host microcontroller end of the display port
`timescale 1ns/1ps
`default_nettype none
module dhi_host (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // pins
  dhi_if.host             pins,
  // static mode straps and the external clock
  input  wire logic       serial_i,
  input  wire logic       enable_strobe_i,
  input  wire logic       wide9_i,
  input  wire logic       ext_clk_i,
  // requests
  input  wire logic       req_valid_i,
  input  wire logic       req_write_i,
  input  wire logic       req_cmd_i,
  input  wire logic [8:0] req_data_i,
  output logic            req_ready_o,
  // answers
  output logic            rsp_valid_o,
  output logic [8:0]      rsp_data_o
);
  dhi_pkg::dhi_hstate_t st_q;
  logic [4:0] tmr_q;
  logic [2:0] bit_q;
  logic       wr_q;
  logic [8:0] sh_q;
  logic       rst_n_q;
  logic       cs_n_q;
  logic       rs_q;
  logic       rd_q;
  logic       ws_q;
  logic [8:0] bo_q;
  logic [8:0] boe_n_q;
  logic       tdone;

  assign tdone = (tmr_q == 5'h00);
  assign pins.chip_reset_low        = rst_n_q;
  assign pins.chip_select_low       = cs_n_q;
  assign pins.command_data_select   = rs_q;
  assign pins.read_strobe           = rd_q;
  assign pins.write_strobe          = ws_q;
  assign pins.interface_type_select = ~serial_i;
  assign pins.cpu_type_select       = enable_strobe_i;
  assign pins.osc_trim_in           = ext_clk_i;
  // video inputs tied high; trigger pin is left unread
  assign pins.frame_sync_in   = 1'b1;
  assign pins.line_sync_in    = 1'b1;
  assign pins.pixel_clock_in  = 1'b1;
  assign pins.video_enable_in = 1'b1;
  assign pins.host_bus_h      = bo_q;
  assign pins.host_bus_h_oe_n = boe_n_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= dhi_pkg::HS_IDLE;
      tmr_q <= 5'h00;
      bit_q <= 3'h0;
      wr_q <= 1'b0;
      sh_q <= 9'h000;
      rst_n_q <= 1'b0;
      cs_n_q <= 1'b1;
      rs_q <= 1'b1;
      rd_q <= 1'b1;
      ws_q <= 1'b1;
      bo_q <= 9'h000;
      boe_n_q <= 9'h1ff;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 9'h000;
    end
    else
    begin
      rst_n_q <= 1'b1;
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      if (!tdone)
        tmr_q <= tmr_q - 5'h01;
      case (st_q)
        dhi_pkg::HS_IDLE:
        begin
          // strobes parked: write high, read high except low as the enable in parallel enable mode; static in serial mode
          rd_q <= ~enable_strobe_i | serial_i;
          ws_q <= 1'b1;
          bo_q <= 9'h000;
          boe_n_q <= serial_i ? 9'h040 : 9'h1ff;
          req_ready_o <= rst_n_q;
          if (req_valid_i && req_ready_o)
          begin
            req_ready_o <= 1'b0;
            wr_q <= req_write_i;
            rs_q <= ~req_cmd_i;
            cs_n_q <= 1'b0;
            tmr_q <= serial_i ? dhi_pkg::SCL_LAST : dhi_pkg::PHASE_LAST;
            if (serial_i)
            begin
              sh_q <= {req_data_i[7:0], 1'b0};
              bo_q <= 9'(req_data_i[7]) << dhi_pkg::SDI_BIT;
              bit_q <= 3'h0;
              st_q <= dhi_pkg::HS_SLO;
            end
            else
            begin
              ws_q <= enable_strobe_i ? req_write_i : 1'b1;
              if (req_write_i)
              begin
                bo_q <= wide9_i ? req_data_i : {req_data_i[7:0], 1'b0};
                boe_n_q <= wide9_i ? 9'h000 : 9'h001;
              end
              st_q <= dhi_pkg::HS_SETUP;
            end
          end
        end
        dhi_pkg::HS_SETUP:
          if (tdone)
          begin
            if (enable_strobe_i)
              rd_q <= 1'b1;
            else if (wr_q)
              ws_q <= 1'b0;
            else
              rd_q <= 1'b0;
            tmr_q <= dhi_pkg::PHASE_LAST;
            st_q <= dhi_pkg::HS_ACTIVE;
          end
        dhi_pkg::HS_ACTIVE:
          if (tdone)
          begin
            rsp_data_o <= wide9_i ? pins.host_data_bus :
                          {1'b0, pins.host_data_bus[8:1]};
            rd_q <= ~enable_strobe_i;
            ws_q <= enable_strobe_i ? wr_q : 1'b1;
            tmr_q <= dhi_pkg::PHASE_LAST;
            st_q <= dhi_pkg::HS_REL;
          end
        dhi_pkg::HS_SLO:
          if (tdone)
          begin
            bo_q[dhi_pkg::SCL_BIT] <= 1'b1;
            sh_q[0] <= pins.host_data_bus[dhi_pkg::SDO_BIT];
            tmr_q <= dhi_pkg::SCL_LAST;
            st_q <= dhi_pkg::HS_SHI;
          end
        dhi_pkg::HS_SHI:
          if (tdone)
          begin
            bo_q[dhi_pkg::SCL_BIT] <= 1'b0;
            tmr_q <= dhi_pkg::SCL_LAST;
            // after eight captures the low byte holds the read word, msb first
            if (bit_q == dhi_pkg::SER_LAST)
            begin
              rsp_data_o <= {1'b0, sh_q[7:0]};
              st_q <= dhi_pkg::HS_REL;
            end
            else
            begin
              bit_q <= bit_q + 3'h1;
              sh_q <= {sh_q[7:0], 1'b0};
              // bit 8 is already on the pin, so the next bit comes from below it
              bo_q[dhi_pkg::SDI_BIT] <= sh_q[7];
              st_q <= dhi_pkg::HS_SLO;
            end
          end
        dhi_pkg::HS_REL:
          if (tdone)
          begin
            cs_n_q <= 1'b1;
            boe_n_q <= serial_i ? 9'h040 : 9'h1ff;
            bo_q <= 9'h000;
            rsp_valid_o <= 1'b1;
            st_q <= dhi_pkg::HS_IDLE;
          end
        default:
          st_q <= dhi_pkg::HS_IDLE;
      endcase
    end
  end

endmodule : dhi_host
`default_nettype wire

// ===== dhi_port_asserts.sv
// concurrent checks on the pins between the two ends of the host port
`timescale 1ns/1ps
`default_nettype none
module dhi_port_asserts (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // pins
  input wire logic       chip_reset_low,
  input wire logic       chip_select_low,
  input wire logic       read_strobe,
  input wire logic       write_strobe,
  input wire logic       interface_type_select,
  input wire logic       cpu_type_select,
  input wire logic       frame_sync_in,
  input wire logic       line_sync_in,
  input wire logic       pixel_clock_in,
  input wire logic       video_enable_in,
  input wire logic       vsync_trigger_out,
  input wire logic [8:0] host_data_bus,
  input wire logic [8:0] host_bus_d_oe_n
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_sep_read;
    interface_type_select && !cpu_type_select && !chip_select_low && !read_strobe;
  endsequence
  sequence s_es_read;
    interface_type_select && cpu_type_select && !chip_select_low && read_strobe
      && !write_strobe;
  endsequence
  sequence s_write;
    interface_type_select && !chip_select_low
      && (cpu_type_select ? (read_strobe && write_strobe) : !write_strobe);
  endsequence
  sequence s_serial_sel;
    !interface_type_select && !chip_select_low;
  endsequence
  chk_reset_pin_init: assert property (
    !chip_reset_low |=> (&host_bus_d_oe_n) && !vsync_trigger_out)
    else $error("device kept driving while held in reset");
  chk_cs_idle_quiet: assert property (
    chip_select_low && $past(chip_select_low) |-> &host_bus_d_oe_n)
    else $error("device drove pins while not selected");
  chk_sep_read_drive: assert property (
    s_sep_read ##1 s_sep_read |-> host_bus_d_oe_n[8:1] == 8'h00)
    else $error("separate strobe read not driven");
  chk_es_read_drive: assert property (
    s_es_read ##1 s_es_read |-> host_bus_d_oe_n[8:1] == 8'h00)
    else $error("enable strobe read not driven");
  chk_write_bus_free: assert property (s_write ##1 s_write |-> &host_bus_d_oe_n)
    else $error("device drove bus during a write");
  chk_serial_out_pin: assert property (
    s_serial_sel ##1 s_serial_sel |-> host_bus_d_oe_n == 9'h1bf)
    else $error("serial output pin map wrong");
  chk_serial_strobes_held: assert property (
    !interface_type_select && chip_reset_low && $past(chip_reset_low)
    |-> $stable(read_strobe) && $stable(write_strobe))
    else $error("strobes toggled in serial mode");
  chk_serial_unused_low: assert property (
    !interface_type_select && chip_reset_low |-> host_data_bus[5:0] == 6'h00)
    else $error("unused serial pins not low");
  chk_video_tied_high: assert property (
    chip_reset_low |-> frame_sync_in && line_sync_in && pixel_clock_in && video_enable_in)
    else $error("video inputs not tied high");
endmodule : dhi_port_asserts
`default_nettype wire

// ===== display_host_interface_select_test.sv
// self-checking bench joining the host and display ends of the port
`timescale 1ns/1ps
`default_nettype none
module display_host_interface_select_test;
  logic        ref_clk_i = 1'b0;
  logic        rst = 1'b1;
  logic        rst_pin = 1'b0;
  logic        serial = 1'b0;
  logic        es_mode = 1'b0;
  logic        wide9 = 1'b1;
  logic        ext_mode = 1'b0;
  logic        osc = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_cmd = 1'b0;
  logic [8:0]  req_data = 9'h000;
  logic [8:0]  rd_data = 9'h000;
  logic        host_rst;
  logic        req_ready, rsp_valid, wr_valid, wr_cmd, display_on, sys_tick;
  logic [8:0]  rsp_data, wr_data;
  logic [9:0]  wr_q[$];
  logic [10:0] rs_q[$];
  logic [10:0] rsp_e;
  logic [9:0]  wr_e;
  int          err_count = 0;
  int          total_checks = 0;
  assign host_rst = rst | rst_pin;
  always #2.5 ref_clk_i = ~ref_clk_i;
  dhi_if pins_if ();
  dhi_dev dhi_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst), .pins(pins_if), .wide9_i(wide9),
    .ext_clk_mode_i(ext_mode), .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_cmd_o(wr_cmd),
    .wr_data_o(wr_data), .display_on_o(display_on), .sys_tick_o(sys_tick));
  dhi_host dhi_host_inst (.ref_clk_i(ref_clk_i), .rst_i(host_rst), .pins(pins_if),
    .serial_i(serial), .enable_strobe_i(es_mode), .wide9_i(wide9), .ext_clk_i(osc),
    .req_valid_i(req_valid), .req_write_i(req_write), .req_cmd_i(req_cmd),
    .req_data_i(req_data), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  dhi_port_asserts dhi_port_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst),
    .chip_reset_low(pins_if.chip_reset_low), .chip_select_low(pins_if.chip_select_low),
    .read_strobe(pins_if.read_strobe), .write_strobe(pins_if.write_strobe),
    .interface_type_select(pins_if.interface_type_select),
    .cpu_type_select(pins_if.cpu_type_select), .frame_sync_in(pins_if.frame_sync_in),
    .line_sync_in(pins_if.line_sync_in), .pixel_clock_in(pins_if.pixel_clock_in),
    .video_enable_in(pins_if.video_enable_in), .vsync_trigger_out(pins_if.vsync_trigger_out),
    .host_data_bus(pins_if.host_data_bus), .host_bus_d_oe_n(pins_if.host_bus_d_oe_n));

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // a full reset is the only safe moment to change the static straps
  task automatic setup(input logic s, input logic e, input logic w, input logic x);
    serial <= s;
    es_mode <= e;
    wide9 <= w;
    ext_mode <= x;
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("display after reset", {9'h000, display_on}, 10'h000);
  endtask : setup

  task automatic send(input logic wr, input logic cmd, input logic [8:0] d);
    int n;
    logic [8:0] v;
    v = (wide9 && !serial) ? d : {1'b0, d[7:0]};
    req_valid <= 1'b1;
    req_write <= wr;
    req_cmd <= cmd;
    req_data <= d;
    if (!wr)
      rd_data <= d;
    n = 0;
    do @(posedge ref_clk_i); while (req_ready !== 1'b1 && ++n < 100);
    // the serial link commits every word it shifts in, a read too
    if (wr || serial)
      wr_q.push_back({cmd, v});
    rs_q.push_back({!wr, 1'b0, v});
    req_valid <= 1'b0;
    n = 0;
    do @(posedge ref_clk_i); while (rsp_valid !== 1'b1 && ++n < 400);
    if (n >= 400)
      check("answer wait", 10'h000, 10'h001);
  endtask : send

  always @(posedge ref_clk_i)
  begin
    if (wr_valid === 1'b1)
    begin
      wr_e = (wr_q.size() != 0) ? wr_q.pop_front() : 10'hx;
      check("written word", {wr_cmd, wr_data}, wr_e);
    end
    if (rsp_valid === 1'b1)
    begin
      rsp_e = (rs_q.size() != 0) ? rs_q.pop_front() : {1'b1, 10'hx};
      if (rsp_e[10])
        check("read word", {1'b0, rsp_data}, rsp_e[9:0]);
    end
  end

  initial
  begin
    int n;
    logic [8:0] d;
    logic cmd;
    void'($urandom(32'h2aadb237));
    @(posedge ref_clk_i);
    // modes: sep 9-bit, sep 8-bit, enable 9-bit, enable 8-bit, serial
    for (int m = 0; m < 5; m++)
    begin
      setup(m == 4, m[1], !m[0], 1'b0);
      send(1'b1, 1'b0, 9'h006);
      check("data word ignored", {9'h000, display_on}, 10'h000);
      send(1'b1, 1'b1, 9'h006);
      check("display on", {9'h000, display_on}, 10'h001);
      send(1'b1, 1'b1, 9'h007);
      check("display off", {9'h000, display_on}, 10'h000);
      repeat (6)
      begin
        d = 9'($urandom);
        cmd = 1'($urandom);
        // random commands stay clear of the display opcodes
        if (cmd)
          d[4] = 1'b1;
        send(1'($urandom), cmd, d);
      end
    end
    setup(1'b0, 1'b0, 1'b1, 1'b0);
    send(1'b1, 1'b1, 9'h006);
    rst_pin <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rst_pin <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("display after pin reset", {9'h000, display_on}, 10'h000);
    n = 0;
    repeat (80)
    begin
      @(posedge ref_clk_i);
      if (sys_tick === 1'b1)
        n++;
    end
    check("internal ticks", 10'(n), 10'h00a);
    setup(1'b0, 1'b0, 1'b1, 1'b1);
    n = 0;
    for (int i = 0; i < 70; i++)
    begin
      @(posedge ref_clk_i);
      osc <= (i < 60) && ((i % 6) >= 3);
      if (sys_tick === 1'b1)
        n++;
    end
    check("external ticks", 10'(n), 10'h00a);
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    end_of_test();
  end
endmodule : display_host_interface_select_test
`default_nettype wire
